// [logic/laser_pkg.sv]
// Purpose: Shared constants for the laser interlock and status logic.
// Assumes: pclk runs at 50 MHz.
// Notes: Times are kept in their own units; cycle counts derive from them.

package laser_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int ENABLE_DELAY_MS = 5000;
   localparam int ENABLE_DELAY_CYC = (CLK_HZ / 1000) * ENABLE_DELAY_MS;
   localparam int TICKLE_GAP_US = 200;
   localparam int TICKLE_GAP_CYC = (CLK_HZ / 1_000_000) * TICKLE_GAP_US;
   localparam int TICKLE_WIDTH_US = 2;
   localparam int TICKLE_WIDTH_CYC = (CLK_HZ / 1_000_000) * TICKLE_WIDTH_US;
   localparam int STUCK_HIGH_US = 1000;
   localparam int STUCK_HIGH_CYC = (CLK_HZ / 1_000_000) * STUCK_HIGH_US;
   localparam int DEBOUNCE_US = 1;
   localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'h08;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;

   localparam int CTRL_FITTED_BIT = 0;
   localparam int CTRL_INHIBIT_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   localparam int ST_READY_BIT = 0;
   localparam int ST_ARMED_BIT = 1;
   localparam int ST_COUNT_BIT = 2;
   localparam int ST_EMISSION_LAMP_BIT = 3;
   localparam int ST_FAULT_BIT = 4;
   localparam int ST_STUCK_BIT = 5;
   localparam int ST_ILOCK_BIT = 6;
   localparam int ST_SHUT_BIT = 7;

   localparam int IRQ_ARMED_BIT = 0;
   localparam int IRQ_ILOCK_LOST_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;
   localparam int IRQ_STUCK_BIT = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] IRQ_RESET = 4'h0;

endpackage : laser_pkg

// [logic/emission_lamp_if.sv]
// Purpose: Carries the power command path between control and pulse monitor.
// Assumes: One clock domain.
// Notes: None.

`timescale 1ns/100ps

interface emission_lamp_if;
   logic cmd;
   logic enable;
   logic stuck;
   logic tickle;
   logic drive;

   modport ctl (output cmd, output enable, input stuck, input tickle, input drive);
   modport mon (input cmd, input enable, output stuck, output tickle, output drive);
endinterface : emission_lamp_if

// [logic/input_debounce.sv]
// Purpose: Synchronises and debounces slow user inputs.
// Assumes: Inputs change far slower than the debounce time.
// Notes: Output follows only after the input is stable for CNT cycles.

`timescale 1ns/100ps

module input_debounce #(
   parameter int W = 3,
   parameter int CNT = laser_pkg::DEBOUNCE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] clean
);

   localparam int CW = $clog2(CNT + 1);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         logic sync;
         logic [CW-1:0] stable;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta <= 1'b0;
               sync <= 1'b0;
            end else begin
               meta <= raw[i];
               sync <= meta;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stable <= '0;
               clean[i] <= 1'b0;
            end else if (sync == clean[i]) begin
               stable <= '0;
            end else if (stable == CW'(CNT - 1)) begin
               stable <= '0;
               clean[i] <= sync;
            end else begin
               stable <= stable + 1'b1;
            end
         end
      end
   endgenerate

endmodule : input_debounce

// [logic/pulse_monitor.sv]
// Purpose: Gates the power command, detects full duty and makes tickle pulses.
// Assumes: Command up to 100 kHz.
// Notes: Command is synchronised but not debounced, to keep pulse widths.

`timescale 1ns/100ps

module pulse_monitor #(
   parameter int GAP_CYC = laser_pkg::TICKLE_GAP_CYC,
   parameter int STUCK_CYC = laser_pkg::STUCK_HIGH_CYC,
   parameter int WIDTH_CYC = laser_pkg::TICKLE_WIDTH_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   emission_lamp_if.mon lk
);

   localparam int GW = $clog2(GAP_CYC + 1);
   localparam int SW = $clog2(STUCK_CYC + 1);
   localparam int TW = $clog2(WIDTH_CYC + 1);

   logic meta;
   logic cmd;
   logic [GW-1:0] off_cnt;
   logic [SW-1:0] high_cnt;
   logic [TW-1:0] tick_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         cmd <= 1'b0;
      end else begin
         meta <= lk.cmd;
         cmd <= meta;
      end
   end

   // ----------------------------------------
   // Full duty detection
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_cnt <= '0;
         lk.stuck <= 1'b0;
      end else if (!cmd) begin
         high_cnt <= '0;
         lk.stuck <= 1'b0;
      end else if (high_cnt == SW'(STUCK_CYC - 1)) begin
         lk.stuck <= 1'b1;
      end else begin
         high_cnt <= high_cnt + 1'b1;
      end
   end

   // ----------------------------------------
   // Tickle generator
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_cnt <= '0;
         tick_cnt <= '0;
         lk.tickle <= 1'b0;
      end else if (cmd || !lk.enable) begin
         off_cnt <= '0;
         tick_cnt <= '0;
         lk.tickle <= 1'b0;
      end else if (lk.tickle) begin
         if (tick_cnt == TW'(WIDTH_CYC - 1)) begin
            lk.tickle <= 1'b0;
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + 1'b1;
         end
      end else if (off_cnt == GW'(GAP_CYC - 1)) begin
         off_cnt <= '0;
         lk.tickle <= 1'b1;
      end else begin
         off_cnt <= off_cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk.drive <= 1'b0;
      end else begin
         lk.drive <= lk.enable && ((cmd && !lk.stuck) || lk.tickle);
      end
   end

endmodule : pulse_monitor

// [logic/laser_interlock_status_logic.sv]
// Purpose: Enable countdown, interlock gating and status outputs of the laser.
// Assumes: APB slave with zero wait states; inputs high when voltage applied.
// Notes: Switched outputs are closed while their output enable is high.
//
// Function
// - Reset/start asserted holds laser disabled.
// - Release lights ready, starts five-second countdown.
// - Lasing only while interlock input asserted.
// - Lasing output closed only while beam emitted.
// - Fault output closed on overtemp or no-strike.
// - Ready output closed while laser enabled.
// - Lasing inhibited five seconds after ready closes.
// - Shutter request enables laser, actuates shutter.
// - Shutter opens only with interlock and ready.
// - Shutter-open output needs interlock and shutter request.
// - Interlock-open output closed while interlock open.
// - Full duty command halts lasing, shows fault.
// - Off time over 200 us emits tickle.
// - Interlock loss clears ready, shutter; not latched.

`timescale 1ns/100ps

module laser_interlock_status_logic #(
   parameter int ENABLE_DELAY_CYC = laser_pkg::ENABLE_DELAY_CYC,
   parameter int TICKLE_GAP_CYC = laser_pkg::TICKLE_GAP_CYC,
   parameter int STUCK_HIGH_CYC = laser_pkg::STUCK_HIGH_CYC,
   parameter int DEBOUNCE_CYC = laser_pkg::DEBOUNCE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic reset_start_req,
   input wire logic interlock_req,
   input wire logic shutter_req,
   input wire logic pwm_cmd,
   input wire logic temp_over,
   input wire logic no_strike,
   output logic rf_drive,
   output logic motorized_beam_blocker,
   output logic emission_lamp,
   output logic overtemp_lamp,
   output logic shutter_lamp,
   output logic [4:0] switched_out,
   output logic [4:0] switched_oe
);

   localparam int CW = $clog2(ENABLE_DELAY_CYC + 1);

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_COUNT,
      ST_ARMED
   } enable_state_t;

   enable_state_t state;
   logic [CW-1:0] delay_cnt;
   logic [2:0] clean;
   logic hold_in;
   logic ilock;
   logic shut;
   logic ready;
   logic armed;
   logic lasing;
   logic fault;
   logic [1:0] ctrl;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic [3:0] irq_event;
   logic [3:0] prev;
   logic wr;
   logic rd;
   logic hit;
   logic [7:0] status;

   emission_lamp_if lk ();

   // ----------------------------------------
   // Input conditioning
   // ----------------------------------------
   input_debounce #(
      .W(3),
      .CNT(DEBOUNCE_CYC)
   ) u_debounce (
      .pclk(pclk),
      .presetn(presetn),
      .raw({shutter_req, interlock_req, reset_start_req}),
      .clean(clean)
   );

   assign hold_in = clean[0];
   assign ilock = clean[1];
   assign shut = clean[2];

   // ----------------------------------------
   // Enable countdown
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_HOLD;
         delay_cnt <= '0;
      end else begin
         case (state)
            ST_HOLD: begin
               delay_cnt <= '0;
               if (!hold_in && ilock) begin
                  state <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               if (hold_in || !ilock) begin
                  state <= ST_HOLD;
                  delay_cnt <= '0;
               end else if (delay_cnt == CW'(ENABLE_DELAY_CYC - 1)) begin
                  state <= ST_ARMED;
               end else begin
                  delay_cnt <= delay_cnt + 1'b1;
               end
            end
            ST_ARMED: begin
               if (hold_in || !ilock) begin
                  state <= ST_HOLD;
               end
            end
            default: begin
               state <= ST_HOLD;
            end
         endcase
      end
   end

   assign ready = (state != ST_HOLD);
   assign armed = (state == ST_ARMED);

   // ----------------------------------------
   // Lasing gate
   // ----------------------------------------
   assign lk.cmd = pwm_cmd;
   assign lk.enable = armed && ilock && shut && !hold_in
      && !ctrl[laser_pkg::CTRL_INHIBIT_BIT];

   pulse_monitor #(
      .GAP_CYC(TICKLE_GAP_CYC),
      .STUCK_CYC(STUCK_HIGH_CYC),
      .WIDTH_CYC(laser_pkg::TICKLE_WIDTH_CYC)
   ) u_monitor (
      .pclk(pclk),
      .presetn(presetn),
      .lk(lk.mon)
   );

   assign lasing = lk.drive && lk.enable;
   assign fault = temp_over || no_strike || lk.stuck;

   // ----------------------------------------
   // Pin and lamp outputs
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_drive <= 1'b0;
         emission_lamp <= 1'b0;
         overtemp_lamp <= 1'b0;
         shutter_lamp <= 1'b0;
         motorized_beam_blocker <= 1'b0;
         switched_oe <= 5'h00;
      end else begin
         rf_drive <= lasing;
         emission_lamp <= lasing;
         overtemp_lamp <= temp_over;
         shutter_lamp <= ilock && shut && ready;
         motorized_beam_blocker <= ctrl[laser_pkg::CTRL_FITTED_BIT]
            && shut && ilock && ready;
         switched_oe[0] <= lasing;
         switched_oe[1] <= fault;
         switched_oe[2] <= ready;
         switched_oe[3] <= ilock && shut && ready;
         switched_oe[4] <= !ilock;
      end
   end

   assign switched_out = 5'h00;

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 4'h0;
      end else begin
         prev <= {lk.stuck, fault, ilock, armed};
      end
   end

   always_comb begin
      irq_event = 4'h0;
      irq_event[laser_pkg::IRQ_ARMED_BIT] = armed && !prev[0];
      irq_event[laser_pkg::IRQ_ILOCK_LOST_BIT] = !ilock && prev[1];
      irq_event[laser_pkg::IRQ_FAULT_BIT] = fault && !prev[2];
      irq_event[laser_pkg::IRQ_STUCK_BIT] = lk.stuck && !prev[3];
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;

   always_comb begin
      hit = 1'b1;
      case (paddr)
         laser_pkg::CTRL_ADDR: hit = 1'b1;
         laser_pkg::STATUS_ADDR: hit = 1'b1;
         laser_pkg::IRQ_STAT_ADDR: hit = 1'b1;
         laser_pkg::IRQ_MASK_ADDR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   assign pslverr = psel && penable && !hit;

   always_comb begin
      status = 8'h00;
      status[laser_pkg::ST_READY_BIT] = ready;
      status[laser_pkg::ST_ARMED_BIT] = armed;
      status[laser_pkg::ST_COUNT_BIT] = (state == ST_COUNT);
      status[laser_pkg::ST_EMISSION_LAMP_BIT] = lasing;
      status[laser_pkg::ST_FAULT_BIT] = fault;
      status[laser_pkg::ST_STUCK_BIT] = lk.stuck;
      status[laser_pkg::ST_ILOCK_BIT] = ilock;
      status[laser_pkg::ST_SHUT_BIT] = shut;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= laser_pkg::CTRL_RESET;
         irq_mask <= laser_pkg::IRQ_RESET;
      end else if (wr && paddr == laser_pkg::CTRL_ADDR) begin
         ctrl <= pwdata[1:0];
      end else if (wr && paddr == laser_pkg::IRQ_MASK_ADDR) begin
         irq_mask <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= laser_pkg::IRQ_RESET;
      end else if (wr && paddr == laser_pkg::IRQ_STAT_ADDR) begin
         irq_stat <= (irq_stat & ~pwdata[3:0]) | irq_event;
      end else begin
         irq_stat <= irq_stat | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd && !penable) begin
         case (paddr)
            laser_pkg::CTRL_ADDR: prdata <= {30'h0, ctrl};
            laser_pkg::STATUS_ADDR: prdata <= {24'h0, status};
            laser_pkg::IRQ_STAT_ADDR: prdata <= {28'h0, irq_stat};
            laser_pkg::IRQ_MASK_ADDR: prdata <= {28'h0, irq_mask};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : laser_interlock_status_logic

// [bench/pwm_source.sv]
// Purpose: Machine controller model that makes the power command pulses.
// Assumes: One clock; high_time is set by the bench.
// Notes: A high_time of PERIOD or more gives a command held high.

`timescale 1ns/100ps

module pwm_source #(
   parameter int PERIOD = 500
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] high_time,
   output logic pwm_cmd
);
   logic [15:0] phase;

   // A period of 500 cycles is 100 kHz, the fastest rate allowed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 16'h0;
         pwm_cmd <= 1'h0;
      end else begin
         phase <= (phase == 16'(PERIOD - 1)) ? 16'h0 : phase + 16'h1;
         pwm_cmd <= phase < high_time;
      end
   end
endmodule : pwm_source

// [bench/laser_interlock_status_logic_properties.sv]
// Purpose: Concurrent checks on the ports of the laser status logic.
// Assumes: Counts are the shortened ones handed on by the bind.
// Notes: Helper counters measure how long a level has been held.

`timescale 1ns/100ps

module laser_status_checker #(
   parameter int ENABLE_DELAY_CYC = 200,
   parameter int TICKLE_GAP_CYC = 40,
   parameter int STUCK_HIGH_CYC = 60
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic reset_start_req,
   input wire logic interlock_req,
   input wire logic shutter_req,
   input wire logic pwm_cmd,
   input wire logic temp_over,
   input wire logic no_strike,
   input wire logic rf_drive,
   input wire logic motorized_beam_blocker,
   input wire logic emission_lamp,
   input wire logic overtemp_lamp,
   input wire logic shutter_lamp,
   input wire logic [4:0] switched_oe
);
   logic [15:0] hold_cnt, ilo_cnt, ihi_cnt, slo_cnt, phi_cnt, plo_cnt, rdy_cnt;

   function automatic logic [15:0] inc(input logic [15:0] c);
      return c + {15'h0, c != 16'hffff};
   endfunction : inc

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {hold_cnt, ilo_cnt, ihi_cnt, slo_cnt} <= 64'h0;
         {phi_cnt, plo_cnt, rdy_cnt} <= 48'h0;
      end else begin
         hold_cnt <= reset_start_req ? inc(hold_cnt) : 16'h0;
         ilo_cnt <= !interlock_req ? inc(ilo_cnt) : 16'h0;
         ihi_cnt <= interlock_req ? inc(ihi_cnt) : 16'h0;
         slo_cnt <= !shutter_req ? inc(slo_cnt) : 16'h0;
         phi_cnt <= pwm_cmd ? inc(phi_cnt) : 16'h0;
         plo_cnt <= !pwm_cmd ? inc(plo_cnt) : 16'h0;
         rdy_cnt <= switched_oe[2] ? inc(rdy_cnt) : 16'h0;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence fault_seen;
      ##[1:4] switched_oe[1];
   endsequence

   hold_off_a: assert property (hold_cnt >= 16 |-> !rf_drive && !switched_oe[2])
      else $error("lasing or ready while reset request held");
   ilock_low_a: assert property (ilo_cnt >= 16 |->
      !rf_drive && switched_oe[4] && !switched_oe[3] && !motorized_beam_blocker)
      else $error("interlock open but laser not shut down");
   ilock_closed_a: assert property (ihi_cnt >= 16 |-> !switched_oe[4])
      else $error("interlock open output closed while interlock present");
   shutter_gate_a: assert property (slo_cnt >= 16 |->
      !switched_oe[3] && !motorized_beam_blocker && !shutter_lamp)
      else $error("shutter shown open without request");
   lamp_follows_a: assert property (emission_lamp == rf_drive && switched_oe[0] == rf_drive)
      else $error("emission lamp differs from beam drive");
   fault_out_a: assert property ((temp_over || no_strike) |-> fault_seen)
      else $error("fault output not closed on fault");
   temp_lamp_a: assert property ($past(presetn) |-> overtemp_lamp == $past(temp_over))
      else $error("overtemp lamp does not follow sensor");
   stuck_halt_a: assert property (phi_cnt >= STUCK_HIGH_CYC + 10 |->
      !rf_drive && switched_oe[1])
      else $error("full duty command not halted");
   tickle_gap_a: assert property ($rose(rf_drive) && plo_cnt > 8 |->
      plo_cnt >= TICKLE_GAP_CYC)
      else $error("tickle before the off time ran out");
   enable_wait_a: assert property (rdy_cnt != 0 && rdy_cnt < ENABLE_DELAY_CYC - 5 |->
      !rf_drive)
      else $error("lasing inside the enable delay");
   emission_lamp_ready_a: assert property ($rose(rf_drive) |-> switched_oe[2])
      else $error("lasing without ready");
   bad_addr_a: assert property (psel && penable |->
      pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0c))
      else $error("slave error does not match address");
endmodule : laser_status_checker

bind laser_interlock_status_logic laser_status_checker #(
   .ENABLE_DELAY_CYC(ENABLE_DELAY_CYC), .TICKLE_GAP_CYC(TICKLE_GAP_CYC),
   .STUCK_HIGH_CYC(STUCK_HIGH_CYC)
) laser_status_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .reset_start_req(reset_start_req), .interlock_req(interlock_req),
   .shutter_req(shutter_req), .pwm_cmd(pwm_cmd), .temp_over(temp_over),
   .no_strike(no_strike), .rf_drive(rf_drive), .motorized_beam_blocker(motorized_beam_blocker),
   .emission_lamp(emission_lamp), .overtemp_lamp(overtemp_lamp),
   .shutter_lamp(shutter_lamp), .switched_oe(switched_oe)
);

// [bench/tb_laser_interlock_status_logic.sv]
// Purpose: Self-checking bench for the laser interlock and status logic.
// Assumes: Shortened counts; a pulse source drives the power command.
// Notes: Register table rows first, then hand-written sequences.

`timescale 1ns/100ps

module tb_laser_interlock_status_logic;
   localparam int ENA = 200;
   localparam int GAP = 40;
   localparam int STUCK = 60;
   localparam int PER = 500;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
      logic err;
   } apb_row_t;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, rf_drive, motorized_beam_blocker, err;
   logic emission_lamp, overtemp_lamp, shutter_lamp, pwm_cmd;
   logic [4:0] switched_oe, switched_out;
   logic reset_start_req = 1'h1;
   logic interlock_req = 1'h1;
   logic shutter_req = 1'h1;
   logic temp_over = 1'h0;
   logic no_strike = 1'h0;
   logic [15:0] high_time = 16'h001e;
   logic [6:0] obs;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int n, m;
   apb_row_t rows [9] = '{
      '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h0},
      '{1'h0, 8'h08, 32'h0, 32'h0, 1'h0}, '{1'h1, 8'h00, 32'h1, 32'h0, 1'h0},
      '{1'h0, 8'h00, 32'h0, 32'h1, 1'h0}, '{1'h1, 8'h0c, 32'hff, 32'h0, 1'h0},
      '{1'h0, 8'h0c, 32'h0, 32'hf, 1'h0}, '{1'h1, 8'h10, 32'h1, 32'h0, 1'h1},
      '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1}};

   assign obs = {motorized_beam_blocker, rf_drive, switched_oe};

   always #10 pclk = ~pclk;

   pwm_source #(.PERIOD(PER)) pwm_source_i (.pclk(pclk), .presetn(presetn),
      .high_time(high_time), .pwm_cmd(pwm_cmd));

   laser_interlock_status_logic #(.ENABLE_DELAY_CYC(ENA), .TICKLE_GAP_CYC(GAP),
      .STUCK_HIGH_CYC(STUCK), .DEBOUNCE_CYC(4)) laser_interlock_status_logic_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .reset_start_req(reset_start_req), .interlock_req(interlock_req),
      .shutter_req(shutter_req), .pwm_cmd(pwm_cmd), .temp_over(temp_over),
      .no_strike(no_strike), .rf_drive(rf_drive), .motorized_beam_blocker(motorized_beam_blocker),
      .emission_lamp(emission_lamp), .overtemp_lamp(overtemp_lamp),
      .shutter_lamp(shutter_lamp), .switched_out(switched_out), .switched_oe(switched_oe));

   task automatic end_of_test();
      $display("Checks %0d, errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_for(input int b, input logic v, output int c);
      c = 0;
      while (obs[b] !== v) begin
         @(posedge pclk);
         c++;
      end
   endtask : wait_for

   task automatic settle(input int c);
      repeat (c) @(posedge pclk);
   endtask : settle

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      settle(3);
      chk("outputs_in_reset", 32'h0, {irq, rf_drive, switched_oe});
      settle(3);
      presetn <= 1'h1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].addr, rows[i].data, rd, err);
         if (!rows[i].wr) begin
            chk("rdata", rows[i].exp, rd);
         end
         chk("pslverr", rows[i].err, err);
      end
      settle(30);
      chk("held_off", 32'h0, {rf_drive, switched_oe[2]});
      chk("ilock_out_open", 32'h0, switched_oe[4]);
      reset_start_req <= 1'h0;
      wait_for(2, 1'h1, n);
      chk("ready_out", 32'h1, switched_oe[2]);
      wait_for(5, 1'h1, n);
      chk("enable_delay", 32'h1, n >= ENA - 1 && n <= ENA + 60);
      apb(1'h0, 8'h04, 32'h0, rd, err);
      chk("status_ready", 32'h3, rd & 32'h3);
      chk("irq_armed", 32'h1, irq);
      apb(1'h1, 8'h08, 32'hf, rd, err);
      settle(2);
      chk("irq_cleared", 32'h0, irq);
      reset_start_req <= 1'h1;
      settle(2);
      reset_start_req <= 1'h0;
      settle(20);
      chk("glitch_ignored", 32'h1, switched_oe[2]);
      shutter_req <= 1'h0;
      settle(20);
      chk("shutter_off", 32'h0, {switched_oe[3], shutter_lamp, motorized_beam_blocker});
      m = 0;
      repeat (PER + 20) begin
         @(posedge pclk);
         m += rf_drive;
      end
      chk("no_emission_lamp_unshut", 32'h0, m);
      shutter_req <= 1'h1;
      wait_for(6, 1'h1, n);
      chk("shutter_on", 32'h7, {switched_oe[3], shutter_lamp, motorized_beam_blocker});
      apb(1'h1, 8'h0c, 32'h0, rd, err);
      interlock_req <= 1'h0;
      settle(20);
      chk("ilock_lost", 32'h20, {obs, shutter_lamp});
      chk("irq_masked", 32'h0, irq);
      apb(1'h0, 8'h08, 32'h0, rd, err);
      chk("lost_event", 32'h2, rd & 32'h2);
      apb(1'h1, 8'h0c, 32'hf, rd, err);
      settle(2);
      chk("irq_unmasked", 32'h1, irq);
      apb(1'h1, 8'h08, 32'hf, rd, err);
      settle(2);
      chk("irq_w1c", 32'h0, irq);
      interlock_req <= 1'h1;
      wait_for(2, 1'h1, n);
      settle(100);
      interlock_req <= 1'h0;
      settle(20);
      interlock_req <= 1'h1;
      wait_for(2, 1'h1, n);
      wait_for(5, 1'h1, n);
      chk("restart_delay", 32'h1, n >= ENA - 1 && n <= ENA + 60);
      high_time <= 16'(PER);
      settle(STUCK + 30);
      chk("stuck_halt", 32'h1, {rf_drive, switched_oe[1]});
      high_time <= 16'h001e;
      wait_for(5, 1'h1, n);
      chk("resume", 32'h1, n < PER);
      while (pwm_cmd !== 1'h1) @(posedge pclk);
      while (pwm_cmd !== 1'h0) @(posedge pclk);
      high_time <= 16'h0;
      wait_for(5, 1'h0, n);
      wait_for(5, 1'h1, m);
      chk("tickle_gap", 32'h1, n + m >= GAP && n + m <= GAP + 10);
      wait_for(5, 1'h0, n);
      chk("tickle_width", 32'h1, n >= laser_pkg::TICKLE_WIDTH_CYC - 1);
      temp_over <= 1'h1;
      settle(4);
      chk("overtemp", 32'h3, {switched_oe[1], overtemp_lamp});
      temp_over <= 1'h0;
      no_strike <= 1'h1;
      settle(4);
      chk("no_strike", 32'h1, switched_oe[1]);
      no_strike <= 1'h0;
      settle(4);
      chk("fault_clear", 32'h0, {switched_oe[1], switched_out});
      apb(1'h1, 8'h00, 32'h2, rd, err);
      m = 0;
      repeat (200) begin
         @(posedge pclk);
         m += rf_drive + motorized_beam_blocker;
      end
      chk("inhibit", 32'h0, m);
      end_of_test();
   end
endmodule : tb_laser_interlock_status_logic
